/* File: rtl/mlp_pkg.sv */
package mlp_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 4;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HB_W = 24;

  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_LINE_PARAMETERS = 2'h0;
  localparam logic [1:0] SEL_TRANSMIT_CONTROL = 2'h1;
  localparam logic [1:0] SEL_MODEM_STATUS = 2'h2;
  localparam logic [1:0] SEL_TRANSMIT_DATA_BREAK = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LPR_LINE_LO = 0;
  localparam int LPR_LINE_HI = 1;
  localparam int LPR_BADLINE_BIT = 2;
  localparam int LPR_CFG_LO = 3;
  localparam int LPR_CFG_HI = 12;
  localparam int LO_NIB_LO = 0;
  localparam int LO_NIB_HI = 3;
  localparam int HI_NIB_LO = 8;
  localparam int HI_NIB_HI = 11;
  localparam int TDR_CHAR_LO = 0;
  localparam int TDR_CHAR_HI = 7;
  localparam int BE_LOW = 0;
  localparam int BE_HIGH = 1;

  // ----------------------------------------------------------------
  // Character framing
  // ----------------------------------------------------------------
  localparam logic [1:0] LEN_5BIT = 2'h0;
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;
  localparam logic [2:0] HALVES_BIT = 3'h2;
  localparam logic [2:0] HALVES_STOP_1P5 = 3'h3;
  localparam logic [2:0] HALVES_STOP_2 = 3'h4;
  localparam logic MARK = 1'b1;
  localparam logic SPACE = 1'b0;
  localparam longint HALF_BIT_SCALE = 5;

  // ----------------------------------------------------------------
  // Scanner timing
  // ----------------------------------------------------------------
  localparam int TX_READY_MAX_NS = 1400;
  localparam int TX_READY_MAX_CYC = TX_READY_MAX_NS / CLK_PERIOD_NS;

  // Field order matches line parameter bits 12..3
  typedef struct packed {
    logic rx_en;
    logic [3:0] speed;
    logic odd;
    logic par_en;
    logic stop2;
    logic [1:0] len;
  } mlp_line_cfg_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} mlp_tx_state_t;

  // Clock cycles per half bit; zero marks the unused speed code
  function automatic logic [HB_W-1:0] half_bit_cycles(input logic [3:0] speed, input int clk_hz);
    longint baud_x10;
    baud_x10 = 0;
    unique case (speed)
      4'h0: baud_x10 = 500;
      4'h1: baud_x10 = 750;
      4'h2: baud_x10 = 1100;
      4'h3: baud_x10 = 1345;
      4'h4: baud_x10 = 1500;
      4'h5: baud_x10 = 3000;
      4'h6: baud_x10 = 6000;
      4'h7: baud_x10 = 12000;
      4'h8: baud_x10 = 18000;
      4'h9: baud_x10 = 20000;
      4'ha: baud_x10 = 24000;
      4'hb: baud_x10 = 36000;
      4'hc: baud_x10 = 48000;
      4'hd: baud_x10 = 72000;
      4'he: baud_x10 = 96000;
      default: baud_x10 = 0;
    endcase
    if (baud_x10 == 0)
    begin
      return '0;
    end
    return HB_W'((longint'(clk_hz) * HALF_BIT_SCALE) / baud_x10);
  endfunction

endpackage

/* File: rtl/mlp_tx_line.sv */
`timescale 1ns/1ns
`default_nettype none
module mlp_tx_line #(
  parameter int CLK_HZ = mlp_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  // Line settings
  input wire mlp_pkg::mlp_line_cfg_t cfg,
  input wire logic brk,
  // Character hand-off
  input wire logic load,
  input wire logic [7:0] data,
  output logic empty,
  // Serial output
  output logic txd
);

  mlp_pkg::mlp_tx_state_t state_ff, nxt_state;
  logic [mlp_pkg::HB_W-1:0] hb_cnt_ff, nxt_hb_cnt, hb_lim;
  logic [2:0] halves_ff, nxt_halves, bit_idx_ff, nxt_bit_idx, last_idx, stop_halves;
  logic [7:0] shift_ff, nxt_shift, hold_ff, nxt_hold, mask;
  logic full_ff, nxt_full, line_ff, nxt_line, par_ff, nxt_par, txd_ff, nxt_txd, tick;

  // ----------------------------------------------------------------
  // Half-bit timing and framing
  // ----------------------------------------------------------------
  always_comb
  begin
    hb_lim = mlp_pkg::half_bit_cycles(cfg.speed, CLK_HZ);
    // Unused speed code stops the divider, so the line simply idles
    tick = (hb_lim != '0) && (hb_cnt_ff == hb_lim - 1'b1);
    nxt_hb_cnt = (tick || hb_cnt_ff >= hb_lim) ? '0 : hb_cnt_ff + 1'b1;
    last_idx = mlp_pkg::LEN_BASE_LAST + {1'b0, cfg.len};
    mask = 8'hff >> (2'h3 - cfg.len);
    stop_halves = !cfg.stop2 ? mlp_pkg::HALVES_BIT :
      (cfg.len == mlp_pkg::LEN_5BIT) ? mlp_pkg::HALVES_STOP_1P5 : mlp_pkg::HALVES_STOP_2;
    nxt_state = state_ff;
    nxt_halves = halves_ff;
    nxt_bit_idx = bit_idx_ff;
    nxt_shift = shift_ff;
    nxt_hold = hold_ff;
    nxt_full = full_ff;
    nxt_line = line_ff;
    nxt_par = par_ff;
    if (load && !full_ff)
    begin
      nxt_hold = data;
      nxt_full = 1'b1;
    end
    // A waiting character starts on the last stop tick, so the stop is not stretched
    if (tick && full_ff && (state_ff == mlp_pkg::TX_IDLE ||
      (state_ff == mlp_pkg::TX_STOP && halves_ff == '0)))
    begin
      nxt_state = mlp_pkg::TX_START;
      nxt_shift = hold_ff;
      nxt_par = (^(hold_ff & mask)) ^ cfg.odd;
      nxt_full = 1'b0;
      nxt_line = mlp_pkg::SPACE;
      nxt_halves = mlp_pkg::HALVES_BIT - 1'b1;
    end
    else if (tick && state_ff != mlp_pkg::TX_IDLE && halves_ff != '0)
    begin
      nxt_halves = halves_ff - 1'b1;
    end
    else if (tick)
    begin
      nxt_halves = mlp_pkg::HALVES_BIT - 1'b1;
      unique case (state_ff)
        mlp_pkg::TX_IDLE:
        begin
          nxt_line = mlp_pkg::MARK;
        end
        mlp_pkg::TX_START:
        begin
          nxt_state = mlp_pkg::TX_DATA;
          nxt_bit_idx = '0;
          nxt_line = shift_ff[0];
        end
        mlp_pkg::TX_DATA:
        begin
          nxt_shift = shift_ff >> 1;
          nxt_bit_idx = bit_idx_ff + 1'b1;
          nxt_line = shift_ff[1];
          if (bit_idx_ff == last_idx)
          begin
            nxt_state = cfg.par_en ? mlp_pkg::TX_PARITY : mlp_pkg::TX_STOP;
            nxt_line = cfg.par_en ? par_ff : mlp_pkg::MARK;
            nxt_halves = cfg.par_en ? mlp_pkg::HALVES_BIT - 1'b1 : stop_halves - 1'b1;
          end
        end
        mlp_pkg::TX_PARITY:
        begin
          nxt_state = mlp_pkg::TX_STOP;
          nxt_line = mlp_pkg::MARK;
          nxt_halves = stop_halves - 1'b1;
        end
        mlp_pkg::TX_STOP:
        begin
          nxt_state = mlp_pkg::TX_IDLE;
        end
      endcase
    end
    if (clr)
    begin
      nxt_state = mlp_pkg::TX_IDLE;
      nxt_full = 1'b0;
      nxt_line = mlp_pkg::MARK;
    end
    nxt_txd = brk ? mlp_pkg::SPACE : nxt_line;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= mlp_pkg::TX_IDLE;
      hb_cnt_ff <= '0;
      halves_ff <= '0;
      bit_idx_ff <= '0;
      shift_ff <= '0;
      hold_ff <= '0;
      full_ff <= 1'b0;
      line_ff <= mlp_pkg::MARK;
      par_ff <= 1'b0;
      txd_ff <= mlp_pkg::MARK;
    end
    else
    begin
      state_ff <= nxt_state;
      hb_cnt_ff <= nxt_hb_cnt;
      halves_ff <= nxt_halves;
      bit_idx_ff <= nxt_bit_idx;
      shift_ff <= nxt_shift;
      hold_ff <= nxt_hold;
      full_ff <= nxt_full;
      line_ff <= nxt_line;
      par_ff <= nxt_par;
      txd_ff <= nxt_txd;
    end
  end

  assign empty = !full_ff;
  assign txd = txd_ff;

  a_break_space: assert property (@(posedge clk) disable iff (!rst_n) brk |=> !txd)
    else $error("break bit set but serial output not at space");

endmodule // mlp_tx_line
`default_nettype wire

/* File: rtl/mlp_line_param_tx_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// Function
// - Parameter write lands only on the line named by bits 1:0.
// - Parameter write with bit 2 set changes no line.
// - Length field 4:3 gives five to eight data bits.
// - Stop bit gives one, two, or one and a half units at five bits.
// - Parity enable adds parity on transmit and checks it on receive.
// - Odd bit picks odd parity, clear picks even, ignored without parity.
// - Speed field sets one common rate; code 1111 is unused.
// - Codes 0000 to 1010 give 50 up to 2400 baud.
// - Receiver works only while enabled; init or master clear disables it.
// - Enable bits 3:0 read/write, cleared by resets, bits 7:4 read zero.
// - Scanner halts on enabled empty line and may request interrupt.
// - Halted scanner resumes on character load or enable bit cleared.
// - Ready drops after load and returns within 1.4 us if needed.
// - Reported line number is valid only while ready is set.
// - Terminal ready bits 11:8 read/write, cleared only by bus init.
// - Terminal ready drives modem output on; jumper may copy it to RTS.
// - Modem status shows ring in 3:0 and carrier in 11:8.
// - Loaded character goes to the line the scanner reports.
// - Break bits 11:8 hold that line at space until cleared.
// - Break bits cleared by both resets, work regardless of maintenance mode.
module mlp_line_param_tx_ctrl #(
  parameter int CLK_HZ = mlp_pkg::CLK_HZ
) (
  // Clock and resets
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic BUS_INIT,
  input wire logic MASTER_CLEAR,
  // Register access
  input wire logic [1:0] REG_SEL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [1:0] REG_BE,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // Scanner control and status
  input wire logic MASTER_SCAN_EN,
  input wire logic TX_INT_EN,
  output logic TX_READY,
  output logic [1:0] TX_LINE,
  output logic TX_INT_REQ,
  // Line settings for the receivers
  output mlp_pkg::mlp_line_cfg_t [mlp_pkg::NUM_LINES-1:0] LINE_CFG,
  // Serial and modem pins
  output logic [mlp_pkg::NUM_LINES-1:0] TXD,
  input wire logic [mlp_pkg::NUM_LINES-1:0] RING,
  input wire logic [mlp_pkg::NUM_LINES-1:0] CARRIER,
  input wire logic RTS_JUMPER,
  output logic [mlp_pkg::NUM_LINES-1:0] DTR,
  output logic [mlp_pkg::NUM_LINES-1:0] RTS
);

  localparam int NL = mlp_pkg::NUM_LINES;
  localparam int RDY_MAX_CYC = mlp_pkg::TX_READY_MAX_CYC;

  mlp_pkg::mlp_line_cfg_t [NL-1:0] cfg_ff, nxt_cfg;
  logic [NL-1:0] tcr_ff, nxt_tcr, dtr_ff, nxt_dtr, brk_ff, nxt_brk, line_empty;
  logic [NL-1:0] ring_s1_ff, ring_s2_ff, carr_s1_ff, carr_s2_ff;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [1:0] scan_ff, nxt_scan, lpr_line;
  logic ready_ff, nxt_ready, jmp_s1_ff, jmp_s2_ff;
  logic clr, wr_lpr, wr_tcr, wr_tdr, load_char, pending_other;

  // Two nibbles in the low and high byte, other bits zero
  function automatic logic [15:0] pack_nibbles(input logic [3:0] hi, input logic [3:0] lo);
    pack_nibbles = {4'h0, hi, 4'h0, lo};
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign clr = BUS_INIT || MASTER_CLEAR;
  assign wr_lpr = REG_WR && REG_SEL == mlp_pkg::SEL_LINE_PARAMETERS;
  assign wr_tcr = REG_WR && REG_SEL == mlp_pkg::SEL_TRANSMIT_CONTROL;
  assign wr_tdr = REG_WR && REG_SEL == mlp_pkg::SEL_TRANSMIT_DATA_BREAK;
  assign lpr_line = REG_WDATA[mlp_pkg::LPR_LINE_HI:mlp_pkg::LPR_LINE_LO];
  // A load outside ready would hit a busy line; it is dropped
  assign load_char = wr_tdr && REG_BE[mlp_pkg::BE_LOW] && ready_ff && !clr;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_tcr = tcr_ff;
    nxt_dtr = dtr_ff;
    nxt_brk = brk_ff;
    nxt_rdata = rdata_ff;
    if (wr_lpr && !REG_WDATA[mlp_pkg::LPR_BADLINE_BIT])
    begin
      nxt_cfg[lpr_line] = mlp_pkg::mlp_line_cfg_t'(
        REG_WDATA[mlp_pkg::LPR_CFG_HI:mlp_pkg::LPR_CFG_LO]);
    end
    if (wr_tcr && REG_BE[mlp_pkg::BE_LOW])
    begin
      nxt_tcr = REG_WDATA[mlp_pkg::LO_NIB_HI:mlp_pkg::LO_NIB_LO];
    end
    if (wr_tcr && REG_BE[mlp_pkg::BE_HIGH])
    begin
      nxt_dtr = REG_WDATA[mlp_pkg::HI_NIB_HI:mlp_pkg::HI_NIB_LO];
    end
    // Break works in any maintenance mode: no mode input gates it
    if (wr_tdr && REG_BE[mlp_pkg::BE_HIGH])
    begin
      nxt_brk = REG_WDATA[mlp_pkg::HI_NIB_HI:mlp_pkg::HI_NIB_LO];
    end
    // Other line parameters survive clears but are not to be trusted
    if (clr)
    begin
      nxt_tcr = '0;
      nxt_brk = '0;
      for (int i = 0; i < NL; i++)
      begin
        nxt_cfg[i].rx_en = 1'b0;
      end
    end
    if (BUS_INIT)
    begin
      nxt_dtr = '0;
    end
    if (REG_RD)
    begin
      unique case (REG_SEL)
        mlp_pkg::SEL_TRANSMIT_CONTROL: nxt_rdata = pack_nibbles(dtr_ff, tcr_ff);
        mlp_pkg::SEL_MODEM_STATUS: nxt_rdata = pack_nibbles(carr_s2_ff, ring_s2_ff);
        // Write-only registers read as zero
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cfg_ff <= '0;
      tcr_ff <= '0;
      dtr_ff <= '0;
      brk_ff <= '0;
      rdata_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      tcr_ff <= nxt_tcr;
      dtr_ff <= nxt_dtr;
      brk_ff <= nxt_brk;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter scanner
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_scan = scan_ff;
    nxt_ready = ready_ff;
    if (clr || !MASTER_SCAN_EN)
    begin
      nxt_ready = 1'b0;
    end
    else if (ready_ff)
    begin
      if (load_char || !tcr_ff[scan_ff])
      begin
        nxt_ready = 1'b0;
        nxt_scan = scan_ff + 1'b1;
      end
    end
    else if (tcr_ff[scan_ff] && line_empty[scan_ff])
    begin
      nxt_ready = 1'b1;
    end
    else
    begin
      nxt_scan = scan_ff + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      scan_ff <= '0;
      ready_ff <= 1'b0;
    end
    else
    begin
      scan_ff <= nxt_scan;
      ready_ff <= nxt_ready;
    end
  end

  assign TX_READY = ready_ff;
  assign TX_LINE = scan_ff;
  assign TX_INT_REQ = ready_ff && TX_INT_EN;
  assign REG_RDATA = rdata_ff;
  assign LINE_CFG = cfg_ff;

  // ----------------------------------------------------------------
  // Modem pins
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ring_s1_ff <= '0;
      ring_s2_ff <= '0;
      carr_s1_ff <= '0;
      carr_s2_ff <= '0;
      jmp_s1_ff <= 1'b0;
      jmp_s2_ff <= 1'b0;
    end
    else
    begin
      ring_s1_ff <= RING;
      ring_s2_ff <= ring_s1_ff;
      carr_s1_ff <= CARRIER;
      carr_s2_ff <= carr_s1_ff;
      jmp_s1_ff <= RTS_JUMPER;
      jmp_s2_ff <= jmp_s1_ff;
    end
  end

  assign DTR = dtr_ff;
  assign RTS = dtr_ff & {NL{jmp_s2_ff}};

  // ----------------------------------------------------------------
  // Line transmitters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NL; g++)
  begin : g_line
    mlp_tx_line #(
      .CLK_HZ(CLK_HZ)
    ) u_line (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .clr(clr),
      .cfg(cfg_ff[g]),
      .brk(brk_ff[g]),
      .load(load_char && scan_ff == 2'(g)),
      .data(REG_WDATA[mlp_pkg::TDR_CHAR_HI:mlp_pkg::TDR_CHAR_LO]),
      .empty(line_empty[g]),
      .txd(TXD[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  assign pending_other = |(tcr_ff & line_empty & ~(4'h1 << scan_ff));

  a_lpr_applies: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_lpr && !REG_WDATA[mlp_pkg::LPR_BADLINE_BIT] && !clr
    |=> cfg_ff[$past(lpr_line)] == $past(REG_WDATA[mlp_pkg::LPR_CFG_HI:mlp_pkg::LPR_CFG_LO]))
    else $error("line parameter write not applied to selected line");

  a_lpr_bad_line: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    wr_lpr && REG_WDATA[mlp_pkg::LPR_BADLINE_BIT] && !clr |=> cfg_ff == $past(cfg_ff))
    else $error("nonexistent line write changed settings");

  a_rx_en_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    clr |=> !cfg_ff[0].rx_en && !cfg_ff[1].rx_en && !cfg_ff[2].rx_en && !cfg_ff[3].rx_en)
    else $error("receiver enable survived a clear");

  a_clear_tcr_brk: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    clr |=> tcr_ff == '0 && brk_ff == '0)
    else $error("enable or break bits survived a clear");

  a_ready_halt: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    $rose(TX_READY) |-> $past(tcr_ff[scan_ff] && line_empty[scan_ff]) && TX_LINE == $past(TX_LINE))
    else $error("scanner halted on a line not needing service");

  a_resume_clear: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    ready_ff && !tcr_ff[scan_ff] && MASTER_SCAN_EN && !clr
    |=> !ready_ff && scan_ff == $past(scan_ff) + 2'h1)
    else $error("scanner did not resume after enable cleared");

  a_load_clears: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    load_char |=> !TX_READY && !line_empty[$past(scan_ff)])
    else $error("ready not cleared or character not taken by line");

  a_ready_returns: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    load_char && pending_other |-> ##[1:RDY_MAX_CYC] (TX_READY || !MASTER_SCAN_EN || clr))
    else $error("ready did not return in time");

  a_dtr_keeps: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    MASTER_CLEAR && !BUS_INIT && !wr_tcr |=> DTR == $past(DTR))
    else $error("master clear changed terminal ready");

  a_modem_read: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    REG_RD && REG_SEL == mlp_pkg::SEL_MODEM_STATUS
    |=> REG_RDATA == {4'h0, $past(carr_s2_ff), 4'h0, $past(ring_s2_ff)})
    else $error("modem status read wrong");

endmodule // mlp_line_param_tx_ctrl
`default_nettype wire

/* File: test/mlp_term_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mlp_term_model #(
  parameter int HB = 10
) (
  // Clock and serial
  input wire logic clk,
  input wire logic [3:0] txd,
  // Modem status sources
  input wire logic [3:0] ring_src,
  input wire logic [3:0] car_src,
  output logic [3:0] ring,
  output logic [3:0] carrier,
  // Frame seen on line 1: data, parity, stop
  output logic [9:0] frame
);
  assign ring = ring_src;
  assign carrier = car_src;
  // Samples mid-bit so one cycle of tick skew cannot move a bit
  initial
  begin
    frame = '0;
    forever
    begin
      @(negedge txd[1]);
      repeat (HB) @(posedge clk);
      for (int i = 0; i < 10; i++)
      begin
        repeat (2 * HB) @(posedge clk);
        frame[i] = txd[1];
      end
    end
  end
endmodule // mlp_term_model
`default_nettype wire

/* File: test/mlp_line_param_tx_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module mlp_line_param_tx_ctrl_tb;
  localparam int CLKHZ = 200_000;
  localparam int HB = CLKHZ * 5 / 96_000;
  localparam logic [1:0] lp = mlp_pkg::SEL_LINE_PARAMETERS;
  localparam logic [1:0] tc = mlp_pkg::SEL_TRANSMIT_CONTROL;
  localparam logic [1:0] ms = mlp_pkg::SEL_MODEM_STATUS;
  localparam logic [1:0] td = mlp_pkg::SEL_TRANSMIT_DATA_BREAK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_init = 1'b0;
  logic mclr = 1'b0;
  logic [1:0] sel = 2'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [1:0] be = 2'h0;
  logic [15:0] wdata = 16'h0;
  logic [15:0] rdata;
  logic scan_en = 1'b0;
  logic int_en = 1'b0;
  logic jumper = 1'b0;
  logic rdy, int_req;
  logic [1:0] line;
  mlp_pkg::mlp_line_cfg_t [3:0] cfg;
  logic [3:0] txd, ring, carrier, dtr, rts;
  logic [3:0] ring_src = 4'h0;
  logic [3:0] car_src = 4'h0;
  logic [9:0] frame;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int n_tests = 0;

  always #5 clk = ~clk;

  mlp_line_param_tx_ctrl #(.CLK_HZ(CLKHZ)) mlp_line_param_tx_ctrl_i (
    .REF_CLK(clk), .RESET_N(rst_n), .BUS_INIT(bus_init), .MASTER_CLEAR(mclr),
    .REG_SEL(sel), .REG_WR(wr_en), .REG_RD(rd_en), .REG_BE(be),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .MASTER_SCAN_EN(scan_en),
    .TX_INT_EN(int_en), .TX_READY(rdy), .TX_LINE(line), .TX_INT_REQ(int_req),
    .LINE_CFG(cfg), .TXD(txd), .RING(ring), .CARRIER(carrier),
    .RTS_JUMPER(jumper), .DTR(dtr), .RTS(rts)
  );

  mlp_term_model #(.HB(HB)) mlp_term_model_i (
    .clk(clk), .txd(txd), .ring_src(ring_src), .car_src(car_src),
    .ring(ring), .carrier(carrier), .frame(frame)
  );

  // ----------------------------------------------------------------
  // Bus tasks and result checking
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Strobe dropped a full cycle before the next call can raise it
  task automatic wr(input logic [1:0] s, input logic [1:0] b, input logic [15:0] d);
    sel <= s;
    be <= b;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] s, input logic [15:0] exp);
    sel <= s;
    rd_en <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse_clr(input logic bus);
    bus_init <= bus;
    mclr <= !bus;
    @(posedge clk);
    bus_init <= 1'b0;
    mclr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 141)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("ready_wait", 16'(n < 141), 16'h1);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (rd_seen && exp_q.size() > 0)
      check("rdata", rdata, exp_q.pop_front());
    rd_seen <= rd_en;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    logic [9:0] cf[4];
    void'($urandom(32'h3ca2420c));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check("txd_idle", {12'h0, txd}, 16'h000f);
    for (int i = 0; i < 4; i++)
    begin
      v = 16'($urandom());
      ring_src <= v[3:0];
      car_src <= v[11:8];
      repeat (4) @(posedge clk);
      wr(ms, 2'h3, ~v);
      rd(ms, v & 16'h0f0f);
    end
    v = 16'($urandom()) | 16'h0100;
    jumper <= 1'b1;
    wr(tc, 2'h3, v);
    rd(tc, v & 16'h0f0f);
    #1;
    check("dtr", {12'h0, dtr}, {12'h0, v[11:8]});
    check("rts", {12'h0, rts}, {12'h0, v[11:8]});
    jumper <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("rts_off", {12'h0, rts}, 16'h0);
    wr(tc, 2'h1, ~v);
    rd(tc, {4'h0, v[11:8], 4'h0, ~v[3:0]});
    pulse_clr(1'b0);
    rd(tc, {4'h0, v[11:8], 8'h0});
    pulse_clr(1'b1);
    rd(tc, 16'h0);
    #1;
    check("dtr_init", {12'h0, dtr}, 16'h0);
    for (int l = 0; l < 4; l++)
    begin
      cf[l] = 10'($urandom());
      wr(lp, 2'h0, {3'h0, cf[l], 1'b0, 2'(l)});
      wr(lp, 2'h0, {3'h0, ~cf[l], 1'b1, 2'(l)});
    end
    #1;
    for (int l = 0; l < 4; l++)
      check("cfg", 16'(cfg[l]), 16'(cf[l]));
    pulse_clr(1'b0);
    for (int l = 0; l < 4; l++)
      check("cfg_clr", 16'(cfg[l]), 16'(cf[l] & 10'h1ff));
    // 8 data bits, even parity, 9600 baud on line 1
    wr(lp, 2'h0, 16'h0e59);
    wr(tc, 2'h1, 16'h000a);
    scan_en <= 1'b1;
    int_en <= 1'b1;
    wait_rdy();
    check("line_first", 16'(line), 16'h1);
    check("int_req", 16'(int_req), 16'h1);
    wr(td, 2'h1, 16'h00a7);
    wait_rdy();
    check("line_next", 16'(line), 16'h3);
    wr(tc, 2'h1, 16'h0002);
    #1;
    check("ready_drop", 16'(rdy), 16'h0);
    repeat (25 * HB) @(posedge clk);
    #1;
    check("frame", 16'(frame), 16'h03a7);
    wait_rdy();
    check("line_back", 16'(line), 16'h1);
    int_en <= 1'b0;
    #1;
    check("int_off", 16'(int_req), 16'h0);
    // 5 data bits taken from 8'hf5, odd parity, 1.5 stop on line 1
    wr(lp, 2'h0, 16'h0ee1);
    wr(td, 2'h1, 16'h00f5);
    repeat (25 * HB) @(posedge clk);
    #1;
    check("frame5", 16'(frame), 16'h03d5);
    scan_en <= 1'b0;
    wr(td, 2'h2, 16'h0400);
    #1;
    check("break_on", {12'h0, txd}, 16'h000b);
    repeat (50) @(posedge clk);
    #1;
    check("break_hold", {12'h0, txd}, 16'h000b);
    pulse_clr(1'b0);
    check("break_clr", {12'h0, txd}, 16'h000f);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // mlp_line_param_tx_ctrl_tb
`default_nettype wire
